/* hw/ptm_pkg.sv */
// Purpose: shared constants and types for the phase and millisecond timing block
// Assumes: one core clock; the four host clocks are modelled as a rotating enable
// Notes:   indices and patterns used by the timing logic are named here
package ptm_pkg;

  // ************************************************************
  // clock slots and register sizes
  // ************************************************************
  localparam int unsigned CLK_SLOTS   = 4;   // W, X, Y, Z per bit gate
  localparam int unsigned GATE_STAGES = 7;   // bit-gate shift register length
  localparam int unsigned FREQ_STAGES = 3;   // frequency shift register length
  localparam int unsigned SYNC_FLOPS  = 3;   // pin synchroniser depth

  // slot positions inside the one-hot clock enable
  localparam int unsigned SLOT_W = 0;
  localparam int unsigned SLOT_X = 1;
  localparam int unsigned SLOT_Y = 2;
  localparam int unsigned SLOT_Z = 3;

  // stage positions (zero based) of the bit-gate register
  localparam int unsigned G1 = 0;
  localparam int unsigned G2 = 1;
  localparam int unsigned G3 = 2;
  localparam int unsigned G5 = 4;
  localparam int unsigned G6 = 5;
  localparam int unsigned G7 = 6;

  // stage positions (zero based) of the frequency register
  localparam int unsigned F1 = 0;
  localparam int unsigned F2 = 1;
  localparam int unsigned F3 = 2;

  // reset values
  localparam logic [CLK_SLOTS-1:0]   CLK_RST  = 4'h1;   // start at W
  localparam logic [GATE_STAGES-1:0] GATE_RST = 7'h00;
  localparam logic [FREQ_STAGES-1:0] FREQ_RST = 3'h0;
  localparam logic [SYNC_FLOPS-1:0]  SYNC_RST = 3'h0;

  // ************************************************************
  // carriers
  // ************************************************************
  typedef struct packed {
    logic ring_phase_a;
    logic ring_phase_b;
    logic ring_phase_c;
  } ptm_ring_t;

  typedef struct packed {
    logic bg1_marker;
    logic phase_b_bg2_strobe;
    logic phase_c_bg2_strobe_q;
    logic phase_a_bg1_strobe;
  } ptm_strobe_t;

  typedef struct packed {
    logic [FREQ_STAGES-1:0] freq_stage;
    logic                   freq_rate_toggle;
    logic                   freq_rate_store;
    logic                   half_ms_divider;
  } ptm_freq_t;

endpackage

/* hw/ptm_timing.sv */
// Purpose: bit-gate, phase, special strobe and millisecond timing of the adapter
// Assumes: host sync pins are asynchronous; the four host clocks are a one-hot
//          enable rotating on core_clk, so a bit gate lasts four core cycles
// Notes:   the shift registers converge from any state; rst_n only gives a
//          defined start for simulation
// Function
// - toggle is aligned or half period behind
// - out-of-phase sync forces pattern 11 at gate 10
// - stage 6 set: next inverted toggle sets stage 7
// - stage 6 clear at sync forces toggle set
// - three latch phase ring steps at gate 1
// - phase sync at gate 2 sets B only
// - ring sets C, A, B; clears previous later
// - phase decode uses clock dependent combinations
// - marker sets gate 1, clears gate 2
// - phase B strobe is marker AND ring B
// - phase C strobe spans mid gate 1 to 2
// - phase A strobe spans gate 1 start to 2
// - frequency register converges, repeats three ones, zeros
// - frequency rate counter clocked by phase C strobe
// - store takes inverted toggle; toggle takes store
// - first stage clears on ones, sets when clear
// - alternate stages gated on alternate counter states
// - each frequency stage pulse is the quarter reference
// - divider toggles on each stage 3 pulse
// - sync forces pattern 11, released at host end
// - bit gate spans W, X, Y, Z; shift at W
`timescale 1ns/10ps
`default_nettype none

module ptm_timing (
  input  wire logic                               core_clk,
  input  wire logic                               rst_n,
  input  wire logic                               host_stage5_sync,
  input  wire logic                               host_phase_sync,
  output logic      [ptm_pkg::CLK_SLOTS-1:0]      clk_slot,
  output logic      [ptm_pkg::GATE_STAGES-1:0]    gate_stage,
  output logic                                    bitgate_toggle_q,
  output logic                                    bitgate_toggle_n,
  output logic                                    bit_gate1,
  output logic                                    bit_gate2,
  output ptm_pkg::ptm_ring_t                      ring,
  output logic      [2:0]                         phase_abc_bg1,
  output ptm_pkg::ptm_strobe_t                    strobe,
  output ptm_pkg::ptm_freq_t                      freq
);

  // ************************************************************
  // host pin synchronisers
  // ************************************************************
  logic [ptm_pkg::SYNC_FLOPS-1:0] s5_pipe_r;
  logic [ptm_pkg::SYNC_FLOPS-1:0] ps_pipe_r;
  logic                           s5_sync_r;
  logic                           ps_sync_r;

  // three flops per pin; first flop feeds only the second
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s5_pipe_r <= ptm_pkg::SYNC_RST;
      ps_pipe_r <= ptm_pkg::SYNC_RST;
    end else begin
      s5_pipe_r <= {s5_pipe_r[1:0], host_stage5_sync};
      ps_pipe_r <= {ps_pipe_r[1:0], host_phase_sync};
    end
  end

  // a change counts once the second and third flop agree
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      s5_sync_r <= 1'b0;
      ps_sync_r <= 1'b0;
    end else begin
      if (s5_pipe_r[1] == s5_pipe_r[2]) begin
        s5_sync_r <= s5_pipe_r[2];
      end
      if (ps_pipe_r[1] == ps_pipe_r[2]) begin
        ps_sync_r <= ps_pipe_r[2];
      end
    end
  end

  // ************************************************************
  // clock slot ring
  // ************************************************************
  logic clk_w;
  logic clk_x;
  logic clk_y;
  logic clk_z;

  // one-hot enable steps W, X, Y, Z, one slot per core cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      clk_slot <= ptm_pkg::CLK_RST;
    end else begin
      clk_slot <= {clk_slot[ptm_pkg::CLK_SLOTS-2:0], clk_slot[ptm_pkg::CLK_SLOTS-1]};
    end
  end

  assign clk_w = clk_slot[ptm_pkg::SLOT_W];
  assign clk_x = clk_slot[ptm_pkg::SLOT_X];
  assign clk_y = clk_slot[ptm_pkg::SLOT_Y];
  assign clk_z = clk_slot[ptm_pkg::SLOT_Z];

  // ************************************************************
  // bit-gate toggle and its store latch
  // ************************************************************
  logic toggle_store_r;

  // store captures the toggle at X; used to flip the toggle at Y
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      toggle_store_r <= 1'b0;
    end else if (clk_x) begin
      toggle_store_r <= bitgate_toggle_q;
    end
  end

  // both ends flip on the same Y, so only in phase or 180 degrees late
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      bitgate_toggle_q <= 1'b0;
    end else if (clk_y) begin
      bitgate_toggle_q <= ~toggle_store_r;
    end else if (clk_z && s5_sync_r && !gate_stage[ptm_pkg::G6]) begin
      bitgate_toggle_q <= 1'b1;
    end
  end

  assign bitgate_toggle_n = ~bitgate_toggle_q;

  // ************************************************************
  // bit-gate shift register
  // ************************************************************
  logic                            g_any_upper;
  logic [ptm_pkg::GATE_STAGES-1:0] gate_nxt;

  // twisted ring with self-correcting entry stage and sync forcing
  always_comb begin
    g_any_upper = |gate_stage[ptm_pkg::GATE_STAGES-1:1];
    gate_nxt    = {gate_stage[ptm_pkg::GATE_STAGES-2:0], 1'b0};
    if (gate_stage[ptm_pkg::G1]) begin
      gate_nxt[ptm_pkg::G1] = ~gate_stage[ptm_pkg::G7];
    end else begin
      gate_nxt[ptm_pkg::G1] = ~g_any_upper;
    end
    // sync holds stage 5 set so the register settles on pattern 11
    if (s5_sync_r) begin
      gate_nxt[ptm_pkg::G5] = 1'b1;
    end
  end

  // one shift per bit gate at W; forcing during gate 10 gives pattern 11,
  // and a set stage 6 walks into stage 7 one shift early
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gate_stage <= ptm_pkg::GATE_RST;
    end else if (clk_w) begin
      gate_stage <= gate_nxt;
    end
  end

  // ************************************************************
  // bit gate decodes
  // ************************************************************
  logic clk_wx;
  logic bg1_wx;
  logic bg1_yz;
  logic bg2_wx;
  logic bg2_yz;

  // three signals at W and X, two signals at Y and Z
  assign clk_wx = clk_w | clk_x;
  assign bg1_wx = ~gate_stage[ptm_pkg::G7] & ~gate_stage[ptm_pkg::G2] & bitgate_toggle_n;
  assign bg1_yz = gate_stage[ptm_pkg::G1] & ~gate_stage[ptm_pkg::G2];
  assign bg2_wx = gate_stage[ptm_pkg::G1] & ~gate_stage[ptm_pkg::G3] & bitgate_toggle_q;
  assign bg2_yz = gate_stage[ptm_pkg::G2] & ~gate_stage[ptm_pkg::G3];
  assign bit_gate1 = clk_wx ? bg1_wx : bg1_yz;
  assign bit_gate2 = clk_wx ? bg2_wx : bg2_yz;

  // ************************************************************
  // phase ring counter
  // ************************************************************
  // sync sets B at gate 2; steps at gate 1: set next at X, clear old at Z
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ring <= '0;
    end else if (ps_sync_r && bit_gate2) begin
      ring.ring_phase_a <= 1'b0;
      ring.ring_phase_b <= 1'b1;
      ring.ring_phase_c <= 1'b0;
    end else if (bit_gate1 && clk_x) begin
      if (ring.ring_phase_b && !ring.ring_phase_c) begin
        ring.ring_phase_c <= 1'b1;
      end
      if (ring.ring_phase_c && !ring.ring_phase_a) begin
        ring.ring_phase_a <= 1'b1;
      end
      if (ring.ring_phase_a && !ring.ring_phase_b) begin
        ring.ring_phase_b <= 1'b1;
      end
    end else if (bit_gate1 && clk_z) begin
      if (ring.ring_phase_b && ring.ring_phase_c) begin
        ring.ring_phase_b <= 1'b0;
      end
      if (ring.ring_phase_c && ring.ring_phase_a) begin
        ring.ring_phase_c <= 1'b0;
      end
      if (ring.ring_phase_a && ring.ring_phase_b) begin
        ring.ring_phase_a <= 1'b0;
      end
    end
  end

  // ************************************************************
  // phase decode during bit gate 1
  // ************************************************************
  // index 2 is phase A, 1 phase B, 0 phase C
  always_comb begin
    if (clk_wx) begin
      phase_abc_bg1[2] = bit_gate1 & ring.ring_phase_c & ~ring.ring_phase_b;
      phase_abc_bg1[1] = bit_gate1 & ring.ring_phase_a & ~ring.ring_phase_c;
      phase_abc_bg1[0] = bit_gate1 & ring.ring_phase_b & ~ring.ring_phase_a;
    end else begin
      phase_abc_bg1[2] = bit_gate1 & ring.ring_phase_a & ~ring.ring_phase_b;
      phase_abc_bg1[1] = bit_gate1 & ring.ring_phase_b & ~ring.ring_phase_c;
      phase_abc_bg1[0] = bit_gate1 & ring.ring_phase_c & ~ring.ring_phase_a;
    end
  end

  // ************************************************************
  // special strobes
  // ************************************************************
  // marker sets at Y of gate 1 and clears at Y of gate 2
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      strobe.bg1_marker <= 1'b0;
    end else if (clk_y && bit_gate1) begin
      strobe.bg1_marker <= 1'b1;
    end else if (clk_y && bit_gate2) begin
      strobe.bg1_marker <= 1'b0;
    end
  end

  // registered AND, one core cycle behind its inputs
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      strobe.phase_b_bg2_strobe <= 1'b0;
    end else begin
      strobe.phase_b_bg2_strobe <= strobe.bg1_marker & ring.ring_phase_b;
    end
  end

  // set mid gate 1 of phase C, cleared mid next gate; good only in gate 2
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      strobe.phase_c_bg2_strobe_q <= 1'b0;
    end else if (clk_y && phase_abc_bg1[0]) begin
      strobe.phase_c_bg2_strobe_q <= 1'b1;
    end else if (clk_y && bit_gate2) begin
      strobe.phase_c_bg2_strobe_q <= 1'b0;
    end
  end

  // set at start of gate 1 in phase A, cleared at start of gate 2
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      strobe.phase_a_bg1_strobe <= 1'b0;
    end else if (clk_w && phase_abc_bg1[2]) begin
      strobe.phase_a_bg1_strobe <= 1'b1;
    end else if (clk_w && bit_gate2) begin
      strobe.phase_a_bg1_strobe <= 1'b0;
    end
  end

  // ************************************************************
  // frequency rate counter
  // ************************************************************
  logic freq_step;

  // one shift slot per phase C strobe, at its W clock
  assign freq_step = clk_w & strobe.phase_c_bg2_strobe_q;

  // store keeps the inverted toggle at X; toggle loads it at the next step
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      freq.freq_rate_store <= 1'b0;
    end else if (clk_x) begin
      freq.freq_rate_store <= ~freq.freq_rate_toggle;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      freq.freq_rate_toggle <= 1'b0;
    end else if (freq_step) begin
      freq.freq_rate_toggle <= freq.freq_rate_store;
    end
  end

  // ************************************************************
  // frequency shift register
  // ************************************************************
  logic [ptm_pkg::FREQ_STAGES-1:0] fs_shift;
  logic [ptm_pkg::FREQ_STAGES-1:0] fs_nxt;

  // full shift value, then split into set and reset halves
  always_comb begin
    fs_shift = {freq.freq_stage[ptm_pkg::FREQ_STAGES-2:0], 1'b0};
    if (freq.freq_stage[ptm_pkg::F1]) begin
      fs_shift[ptm_pkg::F1] = ~freq.freq_stage[ptm_pkg::F3];
    end else begin
      fs_shift[ptm_pkg::F1] = ~(freq.freq_stage[ptm_pkg::F2] |
                                freq.freq_stage[ptm_pkg::F3]);
    end
    fs_nxt = freq.freq_stage;
    if (freq.freq_rate_toggle) begin
      // stage 2 may only set; stages 1 and 3 may only clear
      fs_nxt[ptm_pkg::F2] = freq.freq_stage[ptm_pkg::F2] | fs_shift[ptm_pkg::F2];
      fs_nxt[ptm_pkg::F1] = freq.freq_stage[ptm_pkg::F1] & fs_shift[ptm_pkg::F1];
      fs_nxt[ptm_pkg::F3] = freq.freq_stage[ptm_pkg::F3] & fs_shift[ptm_pkg::F3];
    end else begin
      // the opposite halves on the other counter state
      fs_nxt[ptm_pkg::F2] = freq.freq_stage[ptm_pkg::F2] & fs_shift[ptm_pkg::F2];
      fs_nxt[ptm_pkg::F1] = freq.freq_stage[ptm_pkg::F1] | fs_shift[ptm_pkg::F1];
      fs_nxt[ptm_pkg::F3] = freq.freq_stage[ptm_pkg::F3] | fs_shift[ptm_pkg::F3];
    end
  end

  // stage outputs form the quarter millisecond reference pulses
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      freq.freq_stage <= ptm_pkg::FREQ_RST;
    end else if (freq_step) begin
      freq.freq_stage <= fs_nxt;
    end
  end

  // ************************************************************
  // half millisecond divider
  // ************************************************************
  logic stage3_prev_r;

  // remembers stage 3 so that each of its pulses is counted once
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stage3_prev_r <= 1'b0;
    end else begin
      stage3_prev_r <= freq.freq_stage[ptm_pkg::F3];
    end
  end

  // flips at each rising stage 3 pulse, doubling its width
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      freq.half_ms_divider <= 1'b0;
    end else if (freq.freq_stage[ptm_pkg::F3] && !stage3_prev_r) begin
      freq.half_ms_divider <= ~freq.half_ms_divider;
    end
  end

endmodule

`default_nettype wire

/* test/ptm_timing_assertions.sv */
// Purpose: concurrent checks on the ports of the timing block
// Assumes: one clock domain, reset synchronous and active low
// Notes:   sync pins reach the logic three to four cycles late
`timescale 1ns/10ps
`default_nettype none

module ptm_timing_chk (
  input wire logic                            core_clk,
  input wire logic                            rst_n,
  input wire logic                            host_stage5_sync,
  input wire logic                            host_phase_sync,
  input wire logic [ptm_pkg::CLK_SLOTS-1:0]   clk_slot,
  input wire logic [ptm_pkg::GATE_STAGES-1:0] gate_stage,
  input wire logic                            bitgate_toggle_q,
  input wire logic                            bitgate_toggle_n,
  input wire logic                            bit_gate1,
  input wire logic                            bit_gate2,
  input wire ptm_pkg::ptm_ring_t              ring,
  input wire logic [2:0]                      phase_abc_bg1,
  input wire ptm_pkg::ptm_strobe_t            strobe,
  input wire ptm_pkg::ptm_freq_t              freq
);
  logic       ovl;
  logic       b_src;
  logic       f_step;
  logic [2:0] dec_exp;

  // ************************************************************
  // helper terms
  // ************************************************************
  // overlap of two ring latches, strobe source, shift step, phase decode
  assign ovl = (ring[2] & ring[1]) | (ring[1] & ring[0]) | (ring[2] & ring[0]);
  assign b_src = strobe.bg1_marker & ring.ring_phase_b;
  assign f_step = clk_slot[0] & strobe.phase_c_bg2_strobe_q;
  assign dec_exp = (clk_slot[3:2] != 2'h0) ?
                   {ring[2] & ~ring[1], ring[1] & ~ring[0], ring[0] & ~ring[2]} :
                   {ring[0] & ~ring[1], ring[2] & ~ring[0], ring[1] & ~ring[2]};

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence ring_overlap_s;
    ovl[*2] ##1 !ovl;
  endsequence

  sequence phase_sync_held_s;
    host_phase_sync[*6];
  endsequence

  // ************************************************************
  // checks
  // ************************************************************
  chk_slot_rotate: assert property ($past(rst_n) |->
    clk_slot == {$past(clk_slot[2:0]), $past(clk_slot[3])}) else $error("slot out of turn");
  chk_gate_shift_w: assert property ($past(rst_n) && !$past(clk_slot[0]) |->
    $stable(gate_stage)) else $error("bit-gate register moved off W");
  chk_phase_decode: assert property (
    phase_abc_bg1 == ({3{bit_gate1}} & dec_exp)) else $error("phase decode wrong");
  chk_ring_overlap: assert property ($rose(ovl) |-> ring_overlap_s)
    else $error("ring overlap not two clocks");
  chk_phase_sync: assert property (phase_sync_held_s ##0 bit_gate2 |=>
    ring == 3'h2) else $error("phase sync did not select B");
  chk_marker_set: assert property (bit_gate1 && clk_slot[2] |=> strobe.bg1_marker)
    else $error("marker not set");
  chk_marker_clear: assert property (bit_gate2 && clk_slot[2] |=> !strobe.bg1_marker)
    else $error("marker not cleared");
  chk_bstrobe_and: assert property ($past(rst_n) |->
    strobe.phase_b_bg2_strobe == $past(b_src)) else $error("phase B strobe wrong");
  chk_cstrobe_set: assert property (phase_abc_bg1[0] && clk_slot[2] |=>
    strobe.phase_c_bg2_strobe_q) else $error("phase C strobe not set");
  chk_astrobe_span: assert property (phase_abc_bg1[2] && clk_slot[0] |=>
    strobe.phase_a_bg1_strobe[*4] ##1 !strobe.phase_a_bg1_strobe) else $error("phase A span");
  chk_store_inv: assert property (clk_slot[1] |=>
    freq.freq_rate_store == !$past(freq.freq_rate_toggle)) else $error("store not inverse");
  chk_freq_step: assert property ($past(rst_n) && $changed(freq.freq_stage) |->
    $past(f_step)) else $error("frequency register moved off step");
  chk_freq_alt: assert property (f_step && freq.freq_rate_toggle |=>
    !$rose(freq.freq_stage[0]) && !$fell(freq.freq_stage[1]) && !$rose(freq.freq_stage[2]))
    else $error("frequency stages rippled");
  chk_half_flip: assert property ($rose(freq.freq_stage[2]) |=>
    $changed(freq.half_ms_divider)) else $error("divider did not flip");
  chk_toggle_pair: assert property (bitgate_toggle_n == !bitgate_toggle_q)
    else $error("toggle outputs not complementary");
  chk_toggle_flip: assert property (clk_slot[2] |=>
    bitgate_toggle_q != $past(bitgate_toggle_q)) else $error("toggle did not flip at Y");
endmodule

bind ptm_timing ptm_timing_chk chk_u (
  .core_clk(core_clk), .rst_n(rst_n), .host_stage5_sync(host_stage5_sync),
  .host_phase_sync(host_phase_sync), .clk_slot(clk_slot), .gate_stage(gate_stage),
  .bitgate_toggle_q(bitgate_toggle_q), .bitgate_toggle_n(bitgate_toggle_n),
  .bit_gate1(bit_gate1), .bit_gate2(bit_gate2), .ring(ring), .phase_abc_bg1(phase_abc_bg1),
  .strobe(strobe), .freq(freq)
);

`default_nettype wire

/* test/ptm_host_model.sv */
// Purpose: computer side: bit-gate and phase counters driving the sync pins
// Assumes: runs in lockstep with the block's slot ring
// Notes:   start_gate sets the bit gate at which the counter begins
`timescale 1ns/10ps
`default_nettype none

module ptm_host_model (
  input  wire logic       core_clk,
  input  wire logic       run,
  input  wire logic [3:0] start_gate,
  input  wire logic [3:0] clk_slot,
  output logic            host_stage5_sync,
  output logic            host_phase_sync,
  output logic [3:0]      host_gate,
  output logic [1:0]      host_phase
);
  // counters advance after each Z slot; phase moves after bit gate 14
  always_ff @(posedge core_clk) begin
    if (!run) begin
      host_gate <= start_gate;
      host_phase <= 2'h2;
    end else if (clk_slot[ptm_pkg::SLOT_Z]) begin
      host_gate <= (host_gate == 4'hE) ? 4'h1 : host_gate + 4'h1;
      if (host_gate == 4'hE) begin
        host_phase <= (host_phase == 2'h2) ? 2'h0 : host_phase + 2'h1;
      end
    end
  end

  // stage 5 of the computer is set in bit gates 5 to 11
  assign host_stage5_sync = run && (host_gate >= 4'h5) && (host_gate <= 4'hB);
  // phase sync covers bit gates 1 to 3 of phase B
  assign host_phase_sync = run && (host_phase == 2'h1) && (host_gate <= 4'h3);
endmodule

`default_nettype wire

/* test/ptm_timing_tb.sv */
// Purpose: self-checking bench for the phase and millisecond timing block
// Assumes: inputs change 1 ns after the rising edge
// Notes:   one bit gate is 4 cycles, one phase 56, one operation cycle 168
`timescale 1ns/10ps
`default_nettype none

module ptm_timing_tb;
  logic                 core_clk = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 run = 1'b0;
  logic [3:0]           start_gate = 4'h1;
  logic                 s5_sync;
  logic                 ph_sync;
  logic [3:0]           host_gate;
  logic [1:0]           host_phase;
  logic [3:0]           clk_slot;
  logic [6:0]           gate_stage;
  logic                 bit_gate1;
  logic                 bit_gate2;
  ptm_pkg::ptm_ring_t   ring;
  ptm_pkg::ptm_strobe_t strobe;
  ptm_pkg::ptm_freq_t   freq;
  int                   fail_count = 0;
  int                   num_checks = 0;

  // clock
  always #4 core_clk = ~core_clk;

  ptm_timing dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .host_stage5_sync(s5_sync),
    .host_phase_sync(ph_sync), .clk_slot(clk_slot), .gate_stage(gate_stage),
    .bitgate_toggle_q(), .bitgate_toggle_n(), .bit_gate1(bit_gate1), .bit_gate2(bit_gate2),
    .ring(ring), .phase_abc_bg1(), .strobe(strobe), .freq(freq)
  );

  ptm_host_model host_u (
    .core_clk(core_clk), .run(run), .start_gate(start_gate), .clk_slot(clk_slot),
    .host_stage5_sync(s5_sync), .host_phase_sync(ph_sync), .host_gate(host_gate),
    .host_phase(host_phase)
  );

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1;
    end
  endtask

  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // waits for a level on one frequency output, bounded; index 3 is the divider
  task automatic wait_level(input int idx, input logic lvl, input int lim);
    int         n;
    logic [3:0] w;
    n = 0;
    w = {freq.half_ms_divider, freq.freq_stage};
    while (w[idx] !== lvl && n < lim) begin
      tick(1);
      n++;
      w = {freq.half_ms_divider, freq.freq_stage};
    end
    check_val(n < lim, 1'b1);
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  // free run from reset: twisted ring of seven ones then seven zeros
  task automatic test_gate_walk();
    int         m;
    logic [6:0] e;
    while (clk_slot !== 4'h4) tick(1);
    for (int i = 0; i < 28; i++) begin
      m = (i + 1) % 14;
      e = (m <= 7) ? (7'h7F >> (7 - m)) : (7'h7F << (m - 7));
      check_val(gate_stage, e);
      tick(4);
    end
  endtask

  // host starts at gate g; bit gates must lock and stay locked
  task automatic test_sync(input logic [3:0] g);
    logic [3:0] hg;
    rst_n = 1'b0;
    run = 1'b0;
    start_gate = g;
    tick(2);
    rst_n = 1'b1;
    run = 1'b1;
    tick(400);
    while (!(bit_gate1 === 1'b1 && clk_slot === 4'h1)) tick(1);
    hg = host_gate;
    check_val(hg == 4'h1 || hg == 4'h2, 1'b1);
    for (int j = 0; j < 8; j++) begin
      check_val({bit_gate1, bit_gate2}, (j < 4) ? 2'h2 : 2'h1);
      tick(1);
    end
    tick(48);
    check_val({bit_gate1, clk_slot, host_gate}, {1'b1, 4'h1, hg});
  endtask

  // ring follows the computer phase once per phase, order C, A, B
  task automatic test_phase();
    tick(400);
    while (!(bit_gate1 === 1'b1 && clk_slot === 4'h1)) tick(1);
    tick(6);
    for (int k = 0; k < 6; k++) begin
      check_val(ring, 3'h4 >> host_phase);
      tick(56);
    end
  endtask

  // quarter and half millisecond pulse widths in cycles
  task automatic test_freq();
    int n;
    wait_level(2, 1'b0, 4000);
    wait_level(2, 1'b1, 4000);
    for (int p = 0; p < 2; p++) begin
      n = 0;
      while (freq.freq_stage[2] === ~p[0] && n < 2000) begin
        tick(1);
        n++;
      end
      check_val(n, 504);
    end
    wait_level(3, 1'b0, 2000);
    wait_level(3, 1'b1, 2000);
    n = 0;
    while (freq.half_ms_divider === 1'b1 && n < 3000) begin
      tick(1);
      n++;
    end
    check_val(n, 1008);
  endtask

  // ************************************************************
  // main sequence and watchdog
  // ************************************************************
  initial begin
    tick(16);
    rst_n = 1'b1;
    test_gate_walk();
    for (int g = 1; g <= 14; g++) begin
      test_sync(g[3:0]);
    end
    test_phase();
    test_freq();
    wrap_up();
  end

  initial begin
    #400000;
    fail_count++;
    wrap_up();
  end
endmodule

`default_nettype wire
